//--- logic/hbi_pkg.sv
// constants and types for the host bus interface and strap block
package hbi_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int RDY_WAIT_NS   = 100;
    localparam int RDY_WAIT_CYC  =
        (RDY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (RDY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------------
    // register offsets (byte addresses on the register bus)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_STRAP  = 12'h000;
    localparam logic [11:0] OFS_MISC   = 12'h004;
    localparam logic [11:0] OFS_CRT11  = 12'h008;
    localparam logic [11:0] OFS_VSW    = 12'h00C;
    localparam logic [11:0] OFS_COMPAT = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int STRAP_BUS_TYPE = 0;
    localparam int STRAP_ROM      = 1;
    localparam int STRAP_OSC      = 2;
    localparam int STRAP_MEMCLK   = 3;
    localparam int STRAP_NOWAIT   = 4;
    localparam int MISC_CLK_LO    = 2;
    localparam int CRT11_IRQ_EN   = 5;
    localparam int COMPAT_LEGACY  = 0;
    localparam int COMPAT_SEL_LO  = 1;
    localparam int COMPAT_IRQ_POL = 7;
    localparam int ST_IRQ         = 0;
    localparam int ST_BUSY        = 1;
    localparam int ST_DAC_LO      = 2;
    localparam int ST_SENSE       = 4;
    localparam int ST_SETUP_EN    = 5;
    localparam logic [7:0] STRAP_RST = 8'hFF;
    localparam logic [1:0] DAC_ST_READ  = 2'h3;
    localparam logic [1:0] DAC_ST_WRITE = 2'h0;
    localparam logic [1:0] DOT_SEL_EXT  = 2'h1;
    // ------------------------------------------------------------------
    // host bus decode addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] IO_FEAT     = 16'h03C2;
    localparam logic [15:0] IO_DAC_LO   = 16'h03C6;
    localparam logic [15:0] IO_DAC_RDX  = 16'h03C7;
    localparam logic [15:0] IO_DAC_WRX  = 16'h03C8;
    localparam logic [15:0] IO_DAC_HI   = 16'h03C9;
    localparam logic [15:0] IO_SETUP_LO = 16'h0100;
    localparam logic [15:0] IO_SETUP_EN = 16'h0102;
    localparam logic [15:0] IO_SETUP_HI = 16'h0107;
    localparam logic [19:0] ROM_LO  = 20'hC0000;
    localparam logic [19:0] ROM_HI  = 20'hC7FFF;
    localparam logic [19:0] DISP_LO = 20'hA0000;
    localparam logic [19:0] DISP_HI = 20'hBFFFF;
    // ready sequencer states, gray coded along idle-wait-end
    typedef enum logic [1:0] {
        RDY_IDLE = 2'h0,
        RDY_WAIT = 2'h1,
        RDY_END  = 2'h3
    } hbi_rdy_t;
endpackage : hbi_pkg

//--- logic/hbi_top.sv
// host bus interface: straps, bus decode, ready, irq, palette, clock picks
//
// Function
// - latch eight bus lines at bus reset fall
// - strap bit zero picks bus style
// - strap bit one enables boot rom select
// - strap bit two: clock pins in or out
// - strap bit three picks memory clock source while strap bit two is set
// - strap bit four low enables zero wait
// - buffer enable low, direction high in reset
// - zero wait: address pin doubles as sense
// - rom select pin muxed with no-wait
// - zero wait: sense pin is system clock
// - ready low, then high, then released
// - frame irq set at vsync, cleared rewrite
// - address enable: io valid or mem/io
// - refresh low blocks memory accesses
// - alternate bus status decode and command
// - setup strobe: only setup ports respond
// - palette read strobe, own answer 3C7
// - palette write strobe on four ports
// - internal mode picks dot clock by misc
// - external mode drives picks, fixed inputs
// - legacy mode reads virtual switch bit
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module hbi_top #(
    parameter int RDY_CYC = hbi_pkg::RDY_WAIT_CYC
) (
    // system
    input  wire logic        clk,
    input  wire logic        rst,
    // register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // host bus pins
    input  wire logic [11:0] bus_addr_hi,
    input  wire logic [7:0]  ad_bus,
    output logic      [7:0]  ad_drv,
    output logic             ad_drv_oe_n,
    input  wire logic        io_rd_n,
    input  wire logic        io_wr_n,
    input  wire logic        mem_rd_n,
    input  wire logic        mem_wr_n,
    input  wire logic        addr_en,
    input  wire logic        refresh_n,
    input  wire logic        bus_reset,
    input  wire logic        sense_pin,
    // buffer, strobe and status pins
    output logic             addr_buf_en_n,
    output logic             xcvr_write_n,
    output logic             boot_rom_sel_n,
    output logic             rdy_lvl,
    output logic             rdy_oe_n,
    output logic             irq_pin,
    output logic             dac_rd_n,
    output logic             dac_wr_n,
    // clock selection
    output logic             ext_clk_pick_lo,
    output logic             ext_clk_pick_hi,
    output logic             ext_clk_pick_oe_n,
    output logic      [1:0]  dot_clk_sel,
    output logic             mem_clk_sel,
    // video timing
    input  wire logic        vsync
);
    import hbi_pkg::*;

    localparam int PIN_W = 28;

    typedef struct packed {
        logic [PIN_W-1:0] sy1;
        logic [PIN_W-1:0] sy2;
        logic             brst_d;
        logic             sclk_d;
        logic [7:0]       strap;
        logic [7:0]       misc;
        logic [7:0]       crt11;
        logic [7:0]       vsw;
        logic [7:0]       compat;
        logic             setup_en;
        logic             irq_flag;
        logic [1:0]       dac_state;
        logic [19:0]      addr_lat;
        logic             sense_lat;
        logic             hit_d;
        hbi_rdy_t         st;
        logic [7:0]       wcnt;
        logic             nowait_n;
        logic             rom_sel;
        logic             rom_pin_n;
        logic             irq_out;
        logic             dac_rd_n;
        logic             dac_wr_n;
        logic [7:0]       ad_drv;
        logic             ad_oe_n;
        logic             buf_en_n;
        logic             write_n;
        logic [1:0]       dot_sel;
        logic             mem_sel;
        logic [1:0]       pick;
        logic             pick_oe_n;
        logic [31:0]      prdata;
        logic             pslverr;
    } hbi_state_t;

    hbi_state_t r_r;
    hbi_state_t r_nxt;

    // ------------------------------------------------------------------
    // synchronised pins
    // ------------------------------------------------------------------
    logic [11:0] s_ahi;
    logic [7:0]  s_ad;
    logic        s_iord_n;
    logic        s_iowr_n;
    logic        s_memr_n;
    logic        s_memw_n;
    logic        s_aen;
    logic        s_rfsh_n;
    logic        s_brst;
    logic        s_sense;

    // only the second stage is ever unpacked
    assign {s_ahi, s_ad, s_iord_n, s_iowr_n, s_memr_n, s_memw_n,
            s_aen, s_rfsh_n, s_brst, s_sense} = r_r.sy2;

    // ------------------------------------------------------------------
    // host bus decode
    // ------------------------------------------------------------------
    logic        isa;
    logic        zws;
    logic        osc;
    logic [15:0] io_a;
    logic        alt_mem;
    logic        alt_rd;
    logic        alt_wr;
    logic        alt_cmd;
    logic        alt_setup;
    logic        io_rd;
    logic        io_wr;
    logic        mem_rd;
    logic        mem_wr;
    logic        setup_acc;
    logic        pal_hit;
    logic        pal_rd;
    logic        pal_wr;
    logic        own_rd;
    logic        rom_hit;
    logic        disp_hit;
    logic        card_rd;
    logic        card_wr;
    logic        sense_val;
    logic        feat_bit;
    logic        crt_wr;

    assign isa  = r_r.strap[STRAP_BUS_TYPE];
    assign zws  = !r_r.strap[STRAP_NOWAIT];
    assign osc  = r_r.strap[STRAP_OSC];
    assign io_a = r_r.addr_lat[15:0];

    // alternate bus: status pair, memory/io pin, command and setup
    assign alt_mem   = s_aen;
    assign alt_rd    = !s_memr_n && s_memw_n;
    assign alt_wr    = s_memr_n && !s_memw_n;
    assign alt_cmd   = !isa && !s_iord_n;
    assign alt_setup = !isa && !s_iowr_n;

    // isa io needs the address enable low; setup blocks everything else
    assign io_rd = isa ? (!s_iord_n && !s_aen)
                       : (alt_cmd && !alt_mem && alt_rd && !alt_setup);
    assign io_wr = isa ? (!s_iowr_n && !s_aen)
                       : (alt_cmd && !alt_mem && alt_wr && !alt_setup);
    assign mem_rd = s_rfsh_n && (isa ? !s_memr_n
                  : (alt_cmd && alt_mem && alt_rd && !alt_setup));
    assign mem_wr = s_rfsh_n && (isa ? !s_memw_n
                  : (alt_cmd && alt_mem && alt_wr && !alt_setup));
    assign setup_acc = alt_setup && alt_cmd && !alt_mem &&
                       io_a >= IO_SETUP_LO && io_a <= IO_SETUP_HI;

    assign pal_hit = io_a >= IO_DAC_LO && io_a <= IO_DAC_HI;
    assign pal_rd  = r_r.setup_en && io_rd && pal_hit &&
                     io_a != IO_DAC_RDX;
    assign pal_wr  = r_r.setup_en && io_wr && pal_hit;
    assign own_rd  = (r_r.setup_en && io_rd &&
                      (io_a == IO_DAC_RDX || io_a == IO_FEAT)) ||
                     (setup_acc && alt_rd);
    // rom select qualifies the range and the refresh-gated memory read internally
    assign rom_hit = isa && r_r.strap[STRAP_ROM] && mem_rd &&
                     r_r.addr_lat >= ROM_LO && r_r.addr_lat <= ROM_HI;
    assign disp_hit = r_r.setup_en &&
                      r_r.addr_lat >= DISP_LO && r_r.addr_lat <= DISP_HI;
    assign card_rd = pal_rd || own_rd || rom_hit || (disp_hit && mem_rd);
    assign card_wr = pal_wr || (setup_acc && alt_wr) ||
                     (disp_hit && mem_wr) || (r_r.setup_en && io_wr &&
                     (io_a == IO_DAC_RDX || io_a == IO_DAC_WRX));

    // sense: plain pin, or the address pin while the buffer is off
    assign sense_val = zws ? r_r.sense_lat : s_sense;
    assign feat_bit  = r_r.compat[COMPAT_LEGACY] ?
        r_r.vsw[r_r.compat[COMPAT_SEL_LO +: 3]] : sense_val;
    assign crt_wr    = psel && penable && pwrite && paddr == OFS_CRT11;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        r_nxt     = r_r;
        r_nxt.sy1 = {bus_addr_hi, ad_bus, io_rd_n, io_wr_n, mem_rd_n,
                     mem_wr_n, addr_en, refresh_n, bus_reset, sense_pin};
        r_nxt.sy2 = r_r.sy1;

        // configuration caught on the falling edge of bus reset
        r_nxt.brst_d = s_brst;
        if (r_r.brst_d && !s_brst) begin
            r_nxt.strap = s_ad;
        end

        // address held while the buffer faces the bus; a8 is sense otherwise
        if (!r_r.buf_en_n) begin
            r_nxt.addr_lat = {s_ahi, s_ad};
        end else if (zws) begin
            r_nxt.sense_lat = s_ahi[0];
        end

        // buffer and transceiver: 00 idle, 10 write in, 11 read out
        r_nxt.buf_en_n = card_rd || card_wr;
        r_nxt.write_n  = card_rd;
        if (s_brst) begin
            r_nxt.buf_en_n = 1'b0;
            r_nxt.write_n  = 1'b1;
        end

        // own read data for the dac state, feature and setup ports
        r_nxt.ad_oe_n = !own_rd;
        if (io_a == IO_DAC_RDX) begin
            r_nxt.ad_drv = {6'h00, r_r.dac_state};
        end else if (io_a == IO_FEAT) begin
            r_nxt.ad_drv = {3'h0, feat_bit, 4'h0};
        end else begin
            r_nxt.ad_drv = {7'h00, r_r.setup_en};
        end

        // dac mode follows the last index port written
        if (r_r.setup_en && io_wr && io_a == IO_DAC_RDX) begin
            r_nxt.dac_state = DAC_ST_READ;
        end else if (r_r.setup_en && io_wr && io_a == IO_DAC_WRX) begin
            r_nxt.dac_state = DAC_ST_WRITE;
        end
        if (setup_acc && alt_wr && io_a == IO_SETUP_EN) begin
            r_nxt.setup_en = s_ad[0];
        end

        // palette strobes
        r_nxt.dac_rd_n = !pal_rd;
        r_nxt.dac_wr_n = !pal_wr;

        // no-wait changes only on a rising system clock edge
        r_nxt.sclk_d = s_sense;
        if (zws && s_sense && !r_r.sclk_d) begin
            r_nxt.nowait_n = !(isa && disp_hit && mem_wr);
        end
        r_nxt.rom_sel = rom_hit;
        if (!isa) begin
            r_nxt.rom_pin_n = !(card_rd || card_wr);
        end else if (zws && !s_memw_n) begin
            r_nxt.rom_pin_n = r_r.nowait_n;
        end else begin
            r_nxt.rom_pin_n = !r_r.rom_sel;
        end

        // ready sequencer: hold low, then high one cycle, then release
        r_nxt.hit_d = card_rd || card_wr;
        case (r_r.st)
            RDY_IDLE: begin
                if ((card_rd || card_wr) && !r_r.hit_d) begin
                    r_nxt.st   = RDY_WAIT;
                    r_nxt.wcnt = 8'(RDY_CYC - 1);
                end
            end
            RDY_WAIT: begin
                if (r_r.wcnt == 8'h00) begin
                    r_nxt.st = RDY_END;
                end else begin
                    r_nxt.wcnt = r_r.wcnt - 8'h01;
                end
            end
            RDY_END: begin
                r_nxt.st = RDY_IDLE;
            end
            default: begin
                r_nxt.st = RDY_IDLE;
            end
        endcase

        // frame irq: a vsync in the clearing cycle still sets it
        r_nxt.irq_flag = (r_r.irq_flag && !crt_wr) ||
                         (vsync && r_r.crt11[CRT11_IRQ_EN]);
        r_nxt.irq_out  = r_r.irq_flag ^ !isa ^
                         r_r.compat[COMPAT_IRQ_POL];

        // clock picks
        r_nxt.dot_sel   = osc ? r_r.misc[MISC_CLK_LO +: 2]
                              : DOT_SEL_EXT;
        r_nxt.mem_sel   = osc && !r_r.strap[STRAP_MEMCLK];
        r_nxt.pick      = r_r.misc[MISC_CLK_LO +: 2];
        r_nxt.pick_oe_n = osc;

        // register bus: writes in the access phase
        if (psel && penable && pwrite) begin
            case (paddr)
                OFS_MISC:   r_nxt.misc   = pwdata[7:0];
                OFS_CRT11:  r_nxt.crt11  = pwdata[7:0];
                OFS_VSW:    r_nxt.vsw    = pwdata[7:0];
                OFS_COMPAT: r_nxt.compat = pwdata[7:0];
                default:    r_nxt.misc   = r_r.misc;
            endcase
        end
        // read data and error prepared in the setup phase
        if (psel && !penable) begin
            r_nxt.pslverr = 1'b0;
            case (paddr)
                OFS_STRAP:  r_nxt.prdata = {24'h000000, r_r.strap};
                OFS_MISC:   r_nxt.prdata = {24'h000000, r_r.misc};
                OFS_CRT11:  r_nxt.prdata = {24'h000000, r_r.crt11};
                OFS_VSW:    r_nxt.prdata = {24'h000000, r_r.vsw};
                OFS_COMPAT: r_nxt.prdata = {24'h000000, r_r.compat};
                OFS_STATUS: begin
                    r_nxt.prdata = 32'h00000000;
                    r_nxt.prdata[ST_IRQ]      = r_r.irq_flag;
                    r_nxt.prdata[ST_BUSY]     = r_r.st != RDY_IDLE;
                    r_nxt.prdata[ST_DAC_LO+:2] = r_r.dac_state;
                    r_nxt.prdata[ST_SENSE]    = feat_bit;
                    r_nxt.prdata[ST_SETUP_EN] = r_r.setup_en;
                end
                default: begin
                    r_nxt.prdata  = 32'h00000000;
                    r_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // synchronous reset values
        if (rst) begin
            r_nxt           = '0;
            // sync stages start at idle pin levels, no false strobe
            r_nxt.sy1       = '1;
            r_nxt.sy2       = '1;
            r_nxt.brst_d    = 1'b1;
            r_nxt.sclk_d    = 1'b1;
            r_nxt.strap     = STRAP_RST;
            r_nxt.write_n   = 1'b1;
            r_nxt.ad_oe_n   = 1'b1;
            r_nxt.dac_rd_n  = 1'b1;
            r_nxt.dac_wr_n  = 1'b1;
            r_nxt.nowait_n  = 1'b1;
            r_nxt.rom_pin_n = 1'b1;
            r_nxt.setup_en  = 1'b1;
            r_nxt.pick_oe_n = 1'b1;
            r_nxt.st        = RDY_IDLE;
        end
    end

    // single state register
    always_ff @(posedge clk) begin
        r_r <= r_nxt;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata            = r_r.prdata;
    assign pready            = 1'b1;   // every access completes at once
    assign pslverr           = r_r.pslverr;
    assign ad_drv            = r_r.ad_drv;
    assign ad_drv_oe_n       = r_r.ad_oe_n;
    assign addr_buf_en_n     = r_r.buf_en_n;
    assign xcvr_write_n      = r_r.write_n;
    assign boot_rom_sel_n    = r_r.rom_pin_n;
    assign rdy_lvl           = r_r.st == RDY_END;
    assign rdy_oe_n          = r_r.st == RDY_IDLE;
    assign irq_pin           = r_r.irq_out;
    assign dac_rd_n          = r_r.dac_rd_n;
    assign dac_wr_n          = r_r.dac_wr_n;
    assign ext_clk_pick_lo   = r_r.pick[0];
    assign ext_clk_pick_hi   = r_r.pick[1];
    assign ext_clk_pick_oe_n = r_r.pick_oe_n;
    assign dot_clk_sel       = r_r.dot_sel;
    assign mem_clk_sel       = r_r.mem_sel;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_STRAP_CAPTURE: assert property (
        (r_r.brst_d && !s_brst) |=> r_r.strap == $past(s_ad))
        else $error("strap not latched at bus reset fall");
    AST_ROM_SEL: assert property (
        !r_r.rom_sel || $past(isa && r_r.strap[STRAP_ROM]))
        else $error("rom select without strap enable");
    AST_EXT_PICK: assert property (
        (!osc && $stable(osc) && $stable(r_r.misc)) |=> ##1
        (!ext_clk_pick_oe_n && dot_clk_sel == DOT_SEL_EXT &&
         !mem_clk_sel))
        else $error("external clock mode outputs wrong");
    AST_MEMCLK: assert property (
        (osc && $stable(r_r.strap)) |=>
        mem_clk_sel == !$past(r_r.strap[STRAP_MEMCLK]))
        else $error("memory clock source wrong");
    AST_BUS_RESET: assert property (
        s_brst |=> (!addr_buf_en_n && xcvr_write_n))
        else $error("buffer controls wrong during reset");
    AST_RDY_SEQ: assert property (
        (r_r.st == RDY_WAIT && r_r.wcnt == 8'h00 && !rdy_lvl) |=>
        (rdy_lvl && !rdy_oe_n) ##1 (rdy_oe_n && !rdy_lvl))
        else $error("ready end sequence wrong");
    AST_IRQ_SET: assert property (
        (vsync && r_r.crt11[CRT11_IRQ_EN]) |=> r_r.irq_flag)
        else $error("frame irq flag not set at vsync");
    AST_DAC_RD: assert property (
        pal_rd |=> !dac_rd_n)
        else $error("palette read strobe missing");
    AST_DAC_WR: assert property (
        dac_wr_n || $past(pal_wr))
        else $error("palette write strobe without cause");
    AST_REFRESH: assert property (
        !s_rfsh_n |=> !r_r.rom_sel)
        else $error("memory access during refresh");
    AST_SETUP_ONLY: assert property (
        alt_setup |=> (dac_wr_n && dac_rd_n))
        else $error("palette strobe while setup asserted");
endmodule : hbi_top

//--- dv/hbi_host.sv
// host bus model: straps at bus reset, then isa style io and memory cycles
`timescale 1ns/1ps
module hbi_host (
    // clock from the bench
    input  wire logic        clk,
    // host bus pins toward the device
    output logic      [11:0] bus_addr_hi,
    output logic      [7:0]  ad_bus,
    output logic             io_rd_n,
    output logic             io_wr_n,
    output logic             mem_rd_n,
    output logic             mem_wr_n,
    output logic             addr_en,
    output logic             refresh_n,
    output logic             bus_reset,
    output logic             sense_pin
);
    // bus reset is high from power up, so the device starts in reset state
    initial begin
        {bus_addr_hi, ad_bus} = 20'h00000;
        {io_rd_n, io_wr_n, mem_rd_n, mem_wr_n} = 4'hF;
        {addr_en, refresh_n, bus_reset, sense_pin} = 4'hF;
    end
    // straps stay on the lines well past the reset fall
    task automatic boot(input logic [7:0] v);
        @(posedge clk) ad_bus <= v;
        repeat (5) @(posedge clk);
        bus_reset <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : boot
    // address settles before the strobe; k: 0 io rd, 1 io wr, 2 mem rd
    task automatic start(input logic [1:0] k, input logic [19:0] a);
        @(posedge clk) {bus_addr_hi, ad_bus} <= a;
        addr_en <= k[1];
        repeat (3) @(posedge clk);
        case (k)
            2'h0: io_rd_n <= 1'b0;
            2'h1: io_wr_n <= 1'b0;
            default: mem_rd_n <= 1'b0;
        endcase
    endtask : start
    // all strobes go inactive between cycles
    task automatic stop();
        @(posedge clk) {io_rd_n, io_wr_n, mem_rd_n, mem_wr_n} <= 4'hF;
        addr_en <= 1'b1;
    endtask : stop
endmodule : hbi_host

//--- dv/testbench.sv
// self-checking bench for the host bus interface block
`timescale 1ns/1ps
module testbench;
    import hbi_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        vsync = 0, ad_drv_oe_n, addr_buf_en_n, xcvr_write_n;
    logic [11:0] paddr = 0, bus_addr_hi;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0]  ad_bus, ad_drv, strap;
    logic [1:0]  dot_clk_sel;
    logic        pready, pslverr, io_rd_n, io_wr_n, mem_rd_n, mem_wr_n;
    logic        addr_en, refresh_n, bus_reset, sense_pin, boot_rom_sel_n;
    logic        rdy_lvl, rdy_oe_n, irq_pin, dac_rd_n, dac_wr_n, mem_clk_sel;
    logic        ext_clk_pick_lo, ext_clk_pick_hi, ext_clk_pick_oe_n;
    logic        rlo, rhi, slo, es;
    int          err_count = 0, tests_run = 0;
    hbi_top #(.RDY_CYC(2)) dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .bus_addr_hi, .ad_bus, .ad_drv,
        .ad_drv_oe_n, .io_rd_n, .io_wr_n, .mem_rd_n, .mem_wr_n, .addr_en,
        .refresh_n, .bus_reset, .sense_pin, .addr_buf_en_n, .xcvr_write_n,
        .boot_rom_sel_n, .rdy_lvl, .rdy_oe_n, .irq_pin, .dac_rd_n, .dac_wr_n,
        .ext_clk_pick_lo, .ext_clk_pick_hi, .ext_clk_pick_oe_n,
        .dot_clk_sel, .mem_clk_sel, .vsync);
    hbi_host host (.clk, .bus_addr_hi, .ad_bus, .io_rd_n, .io_wr_n,
        .mem_rd_n, .mem_wr_n, .addr_en, .refresh_n, .bus_reset, .sense_pin);
    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    // apb master: request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
        @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        es = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // one host cycle, watching ready and the strobe it should raise
    task automatic hcyc(input logic [1:0] k, input logic [19:0] a);
        logic own;
        own = k < 2 && a >= 20'h003C6 && a <= 20'h003C9;
        {rlo, rhi, slo} = 3'b000;
        host.start(k, a);
        repeat (8) begin
            @(posedge clk) #1;
            if (!rdy_oe_n && !rdy_lvl) rlo = 1;
            if (!rdy_oe_n && rdy_lvl && rlo) rhi = 1;
            if (!(k == 2 ? boot_rom_sel_n : k[0] ? dac_wr_n : dac_rd_n)) slo = 1;
        end
        chk("strobe", k == 2 ? strap[1] && a <= ROM_HI && a >= ROM_LO &&
            host.refresh_n :
            own && (k[0] || a != 20'h003C7), slo);
        if (own) chk("dir", {1'b1, ~k[0]}, {addr_buf_en_n, xcvr_write_n});
        if (own) chk("ready", 2'b11, {rlo, rhi});
        if (k == 0 && a == 20'h003C7) chk("ad_drv", 0, {ad_drv_oe_n, ad_drv});
        host.stop();
        repeat (6) @(posedge clk);
        #1 chk("rdy_oe_n", 1, rdy_oe_n);
    endtask : hcyc
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'he916));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // isa bus with normal pins, other straps random
        strap = $urandom | 8'h11;
        repeat (2) @(posedge clk) #1;
        chk("reset pins", 2'b01, {addr_buf_en_n, xcvr_write_n});
        host.boot(strap);
        apb(0, OFS_STRAP, 0);
        chk("strap", strap, rd[7:0]);
        chk("pick_oe_n", strap[2], ext_clk_pick_oe_n);
        chk("mem_clk", strap[2] & ~strap[3], mem_clk_sel);
        $display("strap test done");
        for (int i = 0; i < 4; i++) begin
            apb(1, OFS_MISC, i << MISC_CLK_LO);
            repeat (2) @(posedge clk) #1;
            if (strap[2]) chk("dot_sel", i, dot_clk_sel);
            else chk("picks", {DOT_SEL_EXT, 2'(i)},
                {dot_clk_sel, ext_clk_pick_hi, ext_clk_pick_lo});
        end
        $display("clock test done");
        for (int a = 'h3C5; a <= 'h3CA; a++) begin
            hcyc(0, 20'(a));
            hcyc(1, 20'(a));
        end
        hcyc(2, ROM_LO);
        hcyc(2, ROM_HI + 1);
        host.refresh_n = 1'b0;
        hcyc(2, ROM_LO);
        host.refresh_n = 1'b1;
        $display("host cycle test done");
        apb(1, OFS_CRT11, 32'h20);
        @(posedge clk) vsync <= 1'b1;
        @(posedge clk) vsync <= 1'b0;
        repeat (2) @(posedge clk) #1;
        chk("irq set", 1, irq_pin);
        apb(1, OFS_CRT11, 32'h20);
        @(posedge clk) #1 chk("irq clear", 0, irq_pin);
        apb(0, 12'hFFC, 0);
        chk("unmapped", 0, rd);
        chk("slverr", 1, es);
        $display("irq and bus test done");
        end_sim();
    end
endmodule : testbench
